//--- verilog/ovfr_pkg.sv
// package for the overvoltage fault response block
package ovfr_pkg;
   localparam logic [1:0] OVFR_RESP_PULLDOWN = 2'h0;
   localparam logic [1:0] OVFR_RESP_DELAYED = 2'h1;
   localparam logic [1:0] OVFR_RESP_SHUTDOWN = 2'h2;
   localparam logic [1:0] OVFR_RESP_UNSUPP = 2'h3;
   localparam logic [2:0] OVFR_RETRY_CONT = 3'h7;
   localparam int OVFR_RESP_HI = 7;
   localparam int OVFR_RESP_LO = 6;
   localparam int OVFR_RETRY_HI = 5;
   localparam int OVFR_RETRY_LO = 3;
   localparam int OVFR_DELAY_HI = 2;
   localparam int OVFR_DELAY_LO = 0;
   localparam logic [7:0] OVFR_CFG_RESET = 8'hb8;
   localparam int OVFR_CLK_HZ = 10000000;
   localparam int OVFR_DELAY_UNIT_US = 10;
   localparam logic [7:0] OVFR_UNIT_CYC =
      8'((OVFR_CLK_HZ / 1000000) * OVFR_DELAY_UNIT_US);
   localparam int OVFR_RETRY_STEP_MS = 1;
   localparam logic [13:0] OVFR_MS_CYC =
      14'((OVFR_CLK_HZ / 1000) * OVFR_RETRY_STEP_MS);
   localparam logic [16:0] OVFR_RETRY_MIN_MS = 17'h00078;
   localparam logic [16:0] OVFR_RETRY_MAX_MS = 17'h147a8;
   localparam logic [16:0] OVFR_RETRY_RESET_MS = 17'h0015e;

   typedef enum logic [3:0] {
      OVFR_IDLE = 4'h1,
      OVFR_DEGLITCH = 4'h2,
      OVFR_OFF = 4'h4,
      OVFR_RETRY = 4'h8
   } ovfr_state_t;

   typedef struct packed {
      logic wr;
      logic [7:0] data;
   } ovfr_cfg_wr_t;

   typedef struct packed {
      logic fault;
      logic vout_summary;
      logic vout_ov;
      logic alert;
   } ovfr_status_t;

   typedef struct packed {
      ovfr_state_t state;
      logic [7:0] cfg;
      logic [16:0] retry_ms;
      logic [2:0] units;
      logic [7:0] sub;
      logic [13:0] ms_sub;
      logic [16:0] ms;
      logic fault_st;
      logic cml;
      logic run_prev;
      logic out_en;
      logic clamp;
   } ovfr_regs_t;
endpackage : ovfr_pkg

//--- verilog/ovfr_top.sv
// overvoltage fault response decoder and reaction sequencer
`timescale 1ns/1ps
module ovfr_top (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   // configuration writes from the serial port
   input wire ovfr_pkg::ovfr_cfg_wr_t cfg_wr_i,
   input wire logic retry_wr_i,
   input wire logic [16:0] retry_ms_i,
   input wire logic clear_faults_i,
   input wire logic alert_mask_i,
   // channel control and detection
   input wire logic run_control_pin_i,
   input wire logic ov_detect_i,
   // outputs
   output logic [7:0] cfg_o,
   output logic [16:0] retry_ms_o,
   output ovfr_pkg::ovfr_status_t status_o,
   output logic cml_fault_o,
   output logic out_enable_o,
   output logic high_gate_off_o,
   output logic low_gate_on_o
);
   import ovfr_pkg::*;

   logic rst_s1_q, rst_s2_q;
   ovfr_regs_t r_q, r_d;
   logic [1:0] resp;
   logic [2:0] retry, dly;
   logic run_fall;
   logic run_rise;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   assign resp = r_q.cfg[OVFR_RESP_HI:OVFR_RESP_LO];
   assign retry = r_q.cfg[OVFR_RETRY_HI:OVFR_RETRY_LO];
   assign dly = r_q.cfg[OVFR_DELAY_HI:OVFR_DELAY_LO];
   assign run_fall = r_q.run_prev && !run_control_pin_i;
   assign run_rise = !r_q.run_prev && run_control_pin_i;

   always_comb
   begin
      r_d = r_q;
      r_d.run_prev = run_control_pin_i;
      r_d.cml = 1'b0;
      if (cfg_wr_i.wr)
      begin
         if (cfg_wr_i.data[OVFR_RESP_HI:OVFR_RESP_LO] == OVFR_RESP_UNSUPP)
            r_d.cml = 1'b1;
         else
            r_d.cfg = cfg_wr_i.data;
      end
      // out-of-range intervals are refused the same way
      if (retry_wr_i)
      begin
         if (retry_ms_i < OVFR_RETRY_MIN_MS || retry_ms_i > OVFR_RETRY_MAX_MS)
            r_d.cml = 1'b1;
         else
            r_d.retry_ms = retry_ms_i;
      end
      // clear command or off-on of the run pin clears status; a new fault still wins over the clear command
      if (clear_faults_i || run_rise)
         r_d.fault_st = 1'b0;
      r_d.clamp = (resp == OVFR_RESP_PULLDOWN) && ov_detect_i;
      if (r_q.ms_sub != 14'h0000)
         r_d.ms_sub = r_q.ms_sub - 14'h0001;
      else if (r_q.ms != 17'h00000)
      begin
         r_d.ms = r_q.ms - 17'h00001;
         r_d.ms_sub = OVFR_MS_CYC - 14'h0001;
      end
      case (r_q.state)
         OVFR_IDLE:
         begin
            if (ov_detect_i && r_q.out_en)
            begin
               r_d.fault_st = 1'b1;
               // retry timing starts at detection
               r_d.ms = r_q.retry_ms;
               r_d.ms_sub = OVFR_MS_CYC - 14'h0001;
               // a zero delay leaves nothing to deglitch: act at once
               if (resp == OVFR_RESP_SHUTDOWN
                   || (resp == OVFR_RESP_DELAYED && dly == 3'h0))
               begin
                  r_d.out_en = 1'b0;
                  r_d.state = (retry == OVFR_RETRY_CONT) ? OVFR_RETRY
                                                        : OVFR_OFF;
               end
               else if (resp == OVFR_RESP_DELAYED)
               begin
                  // sub times the first unit, so n units total n*10 us
                  r_d.units = dly - 3'h1;
                  r_d.sub = OVFR_UNIT_CYC - 8'h01;
                  r_d.state = OVFR_DEGLITCH;
               end
            end
         end
         OVFR_DEGLITCH:
         begin
            if (!ov_detect_i)
               r_d.state = OVFR_IDLE;
            else if (r_q.sub != 8'h00)
               r_d.sub = r_q.sub - 8'h01;
            else if (r_q.units != 3'h0)
            begin
               r_d.units = r_q.units - 3'h1;
               r_d.sub = OVFR_UNIT_CYC - 8'h01;
            end
            else
            begin
               r_d.out_en = 1'b0;
               r_d.state = (retry == OVFR_RETRY_CONT) ? OVFR_RETRY
                                                     : OVFR_OFF;
            end
         end
         OVFR_OFF:
         begin
            if (clear_faults_i || run_rise)
            begin
               r_d.out_en = run_control_pin_i;
               r_d.state = OVFR_IDLE;
            end
         end
         OVFR_RETRY:
         begin
            if (r_q.ms == 17'h00000 && r_q.ms_sub == 14'h0000)
            begin
               r_d.out_en = run_control_pin_i;
               r_d.state = OVFR_IDLE;
            end
         end
         default:
            r_d.state = OVFR_IDLE;
      endcase
      if (run_fall || !run_control_pin_i)
      begin
         r_d.out_en = 1'b0;
         r_d.state = OVFR_OFF;
      end
      else if (run_rise && r_q.state == OVFR_OFF)
         r_d.out_en = 1'b1;
      if (ov_detect_i && r_q.out_en)
         r_d.fault_st = 1'b1;
   end

   always_ff @(posedge clk_i or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         r_q <= '0;
         r_q.state <= OVFR_OFF;
         r_q.cfg <= OVFR_CFG_RESET;
         r_q.retry_ms <= OVFR_RETRY_RESET_MS;
      end
      else if (clk_en_i)
         r_q <= r_d;
   end

   assign cfg_o = r_q.cfg;
   assign retry_ms_o = r_q.retry_ms;
   assign status_o.fault = r_q.fault_st;
   assign status_o.vout_summary = r_q.fault_st;
   assign status_o.vout_ov = r_q.fault_st;
   assign status_o.alert = r_q.fault_st && !alert_mask_i;
   assign cml_fault_o = r_q.cml;
   assign out_enable_o = r_q.out_en;
   assign high_gate_off_o = r_q.clamp || !r_q.out_en;
   assign low_gate_on_o = r_q.clamp;

   a_bad_code_kept: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
      clk_en_i && cfg_wr_i.wr
      && cfg_wr_i.data[OVFR_RESP_HI:OVFR_RESP_LO] == OVFR_RESP_UNSUPP
      |=> cml_fault_o && cfg_o == $past(cfg_o))
      else $error("unsupported code stored or not flagged");
   a_shut_now: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
      clk_en_i && r_q.state == OVFR_IDLE && ov_detect_i && r_q.out_en
      && resp == OVFR_RESP_SHUTDOWN && run_control_pin_i
      |=> !out_enable_o)
      else $error("shutdown code did not disable output");
   a_fault_sets: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
      clk_en_i && ov_detect_i && r_q.out_en |=> status_o.vout_ov)
      else $error("fault status not set");
   a_sticky_bit: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
      status_o.fault && !clear_faults_i && !run_rise |=> status_o.fault)
      else $error("fault status dropped early");
   a_clamp_only: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
      clk_en_i && resp == OVFR_RESP_PULLDOWN && ov_detect_i
      && !cfg_wr_i.wr |=> low_gate_on_o && high_gate_off_o)
      else $error("pull-down clamp missing");
   a_latch_off: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
      r_q.state == OVFR_OFF && !clear_faults_i && !run_rise
      |=> !out_enable_o)
      else $error("latched output restarted");
   a_delay_hold: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
      r_q.state == OVFR_DEGLITCH && ov_detect_i && run_control_pin_i
      && (r_q.sub != 8'h00 || r_q.units != 3'h0) |=> out_enable_o)
      else $error("delayed response cut output early");
   a_retry_wait: assert property (@(posedge clk_i) disable iff (!rst_s2_q)
      r_q.state == OVFR_RETRY && r_q.ms != 17'h00000 |=> !out_enable_o)
      else $error("retry before interval elapsed");
endmodule : ovfr_top

//--- testbench/ovfr_host.sv
// host model that writes configuration and commands to the block
`timescale 1ns/1ps
module ovfr_host
   import ovfr_pkg::*;
(
   // clock
   input wire logic clk_i,
   // writes toward the block
   output ovfr_cfg_wr_t cfg_wr_o,
   output logic retry_wr_o,
   output logic [16:0] retry_ms_o,
   output logic clear_faults_o
);
   initial
   begin
      cfg_wr_o = '0;
      retry_wr_o = 1'b0;
      retry_ms_o = '0;
      clear_faults_o = 1'b0;
   end
   // sel high writes the interval, low the config byte
   task automatic wr(input logic sel, input logic [16:0] d);
      @(posedge clk_i);
      retry_wr_o <= sel;
      cfg_wr_o.wr <= !sel;
      retry_ms_o <= d;
      cfg_wr_o.data <= d[7:0];
      @(posedge clk_i);
      retry_wr_o <= 1'b0;
      cfg_wr_o.wr <= 1'b0;
      // released data shows garbage, not the last value
      retry_ms_o <= ~d;
      cfg_wr_o.data <= ~d[7:0];
   endtask : wr
   task automatic clear_cmd();
      @(posedge clk_i);
      clear_faults_o <= 1'b1;
      @(posedge clk_i);
      clear_faults_o <= 1'b0;
   endtask : clear_cmd
endmodule : ovfr_host

//--- testbench/testbench.sv
// self-checking bench for the overvoltage fault response block
`timescale 1ns/1ps
module testbench;
   import ovfr_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic run_i = 1'b0;
   logic ov_i = 1'b0;
   logic mask_i = 1'b0;
   ovfr_cfg_wr_t cfg_wr;
   logic retry_wr;
   logic clear;
   logic [16:0] retry_ms;
   logic [7:0] cfg_o;
   logic [16:0] retry_o;
   ovfr_status_t st;
   logic cml;
   logic en;
   logic hgo;
   logic lgo;
   int errors = 0;
   int comparisons = 0;
   // sel, written value, expected stored value, expected refusal
   logic [35:0] rows [10] = '{
      {1'b0, 17'h80, 17'h80, 1'b0}, {1'b0, 17'hc5, 17'h80, 1'b1},
      {1'b0, 17'h47, 17'h47, 1'b0}, {1'b0, 17'hff, 17'h47, 1'b1},
      {1'b0, 17'h7b, 17'h7b, 1'b0}, {1'b1, 17'd119, 17'd350, 1'b1},
      {1'b1, 17'd120, 17'd120, 1'b0}, {1'b1, 17'd83881, 17'd120, 1'b1},
      {1'b1, 17'd83880, 17'd83880, 1'b0}, {1'b0, 17'h00, 17'h00, 1'b0}};
   always #50 clk_i = ~clk_i;
   ovfr_host u_ovfr_host (.clk_i(clk_i), .cfg_wr_o(cfg_wr),
      .retry_wr_o(retry_wr), .retry_ms_o(retry_ms), .clear_faults_o(clear));
   ovfr_top u_ovfr_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .clk_en_i(1'b1), .cfg_wr_i(cfg_wr), .retry_wr_i(retry_wr),
      .retry_ms_i(retry_ms), .clear_faults_i(clear), .alert_mask_i(mask_i),
      .run_control_pin_i(run_i), .ov_detect_i(ov_i), .cfg_o(cfg_o),
      .retry_ms_o(retry_o), .status_o(st), .cml_fault_o(cml),
      .out_enable_o(en), .high_gate_off_o(hgo), .low_gate_on_o(lgo));
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_i);
   endtask : wait_n
   task automatic drive_ov(input logic v);
      @(posedge clk_i);
      ov_i <= v;
   endtask : drive_ov
   task automatic complete_run();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   initial
   begin
      #(6000 * 100);
      errors++;
      complete_run();
   end
   initial
   begin
      repeat (8) @(posedge clk_i);
      reset_n_i <= 1'b1;
      wait_n(3);
      chk(cfg_o, 17'hb8);
      chk(retry_o, 17'd350);
      chk(st, 17'h0);
      foreach (rows[i])
      begin
         u_ovfr_host.wr(rows[i][35], rows[i][34:18]);
         wait_n(1);
         chk(rows[i][35] ? retry_o : cfg_o, rows[i][17:1]);
         chk(cml, rows[i][0]);
      end
      @(posedge clk_i);
      run_i <= 1'b1;
      wait_n(3);
      chk(en, 1'b1);
      drive_ov(1'b1);
      wait_n(3);
      chk({en, hgo, lgo}, 3'h7);
      chk(st, 4'hf);
      chk(st.vout_summary & st.vout_ov, 1'b1);
      @(posedge clk_i);
      mask_i <= 1'b1;
      wait_n(1);
      chk(st.alert, 1'b0);
      drive_ov(1'b0);
      mask_i <= 1'b0;
      wait_n(3);
      chk({en, lgo, st.fault}, 3'h5);
      u_ovfr_host.clear_cmd();
      wait_n(2);
      chk(st.fault, 1'b0);
      u_ovfr_host.wr(1'b0, 17'h80);
      drive_ov(1'b1);
      drive_ov(1'b0);
      wait_n(1);
      chk(en, 1'b0);
      wait_n(50);
      chk({en, st.fault}, 2'h1);
      @(posedge clk_i);
      run_i <= 1'b0;
      wait_n(3);
      @(posedge clk_i);
      run_i <= 1'b1;
      wait_n(3);
      chk({en, st.fault}, 2'h2);
      u_ovfr_host.wr(1'b0, 17'h42);
      drive_ov(1'b1);
      wait_n(100);
      drive_ov(1'b0);
      wait_n(400);
      chk(en, 1'b1);
      // delay 2 is 200 cycles counted from the detecting edge
      drive_ov(1'b1);
      wait_n(201);
      chk(en, 1'b1);
      wait_n(1);
      chk(en, 1'b0);
      drive_ov(1'b0);
      u_ovfr_host.clear_cmd();
      wait_n(2);
      chk({en, st.fault}, 2'h2);
      u_ovfr_host.wr(1'b0, 17'h40);
      drive_ov(1'b1);
      drive_ov(1'b0);
      wait_n(1);
      chk(en, 1'b0);
      u_ovfr_host.clear_cmd();
      u_ovfr_host.wr(1'b0, 17'hb8);
      drive_ov(1'b1);
      drive_ov(1'b0);
      wait_n(300);
      chk({en, st.fault}, 2'h1);
      // bias loss in mid-run: status and settings return to reset
      @(posedge clk_i);
      reset_n_i <= 1'b0;
      wait_n(2);
      chk({en, st}, 5'h00);
      chk(retry_o, 17'd350);
      @(posedge clk_i);
      reset_n_i <= 1'b1;
      wait_n(4);
      chk(en, 1'b1);
      complete_run();
   end
endmodule : testbench
